/* hw/servo_control_mode_selector.sv */
// Command source and dual control mode selection with APB registers
`timescale 1ns/1ps
`default_nettype none

module servo_control_mode_selector #(
   parameter int TICK_CYCLES = servo_mode_pkg::FILTER_STEP_CYCLES
) (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [servo_mode_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire servo_mode_pkg::di_pins_t            di_pins,
   input  wire logic signed [15:0]                  analog_torque_mv,
   input  wire logic signed [15:0]                  analog_speed,
   output servo_mode_pkg::drive_cmd_t               drive_cmd
);
   import servo_mode_pkg::*;

   typedef struct packed {
      di_pins_t                             sync1;
      di_pins_t                             sync2;
      di_pins_t                             deb_last;
      di_pins_t                             stable;
      logic [DEB_W-1:0]                     deb_cnt;
      logic                                 trig_prev;
      logic                                 pulse_prev;
      logic [7:0]                           mode;
      logic [7:0]                           limit_en;
      logic [15:0]                          tau;
      logic [15:0]                          scale;
      logic [15:0]                          max_speed;
      logic [N_TQ_PRESET-1:0][15:0]         tq_pre;
      logic [N_SP_PRESET-1:0][15:0]         sp_pre;
      logic [N_POS_PRESET-1:0][31:0]        pos_pre;
      op_mode_t                             op;
      logic signed [31:0]                   pos;
      logic signed [31:0]                   pcount;
      logic [TICK_W-1:0]                    tick;
      logic signed [15:0]                   filt;
      drive_cmd_t                           out;
      logic [31:0]                          prdata;
      logic                                 pready;
      logic                                 pslverr;
   } state_t;

   localparam logic [DEB_W-1:0]  DEB_CNT_MAX = DEB_W'(DEBOUNCE_CYCLES - 1);
   localparam logic [TICK_W-1:0] TICK_LAST   = TICK_W'(TICK_CYCLES - 1);

   state_t s_q;
   state_t s_d;

   logic [IDX_W-1:0]   idx;
   logic               aligned;
   logic               trig_rise;
   logic               pulse_rise;
   logic signed [15:0] scaled;
   logic signed [15:0] torque_src;
   logic signed [15:0] speed_src;
   logic signed [31:0] pos_sel_value;
   di_pins_t           cur;

   function automatic logic mode_ok(input logic [7:0] code);
      return (code >= MODE_PULSE_SPEED) && (code <= MODE_SPEED_TORQUE);
   endfunction : mode_ok

   function automatic logic in_range(input logic [IDX_W-1:0] i,
                                     input logic [IDX_W-1:0] base,
                                     input int               n);
      return (i >= base) && (i < base + IDX_W'(n));
   endfunction : in_range

   function automatic logic reg_hit(input logic [IDX_W-1:0] i);
      return (i == IDX_CTRL_MODE) || (i == IDX_LIMIT_EN) ||
             (i == IDX_TORQUE_SMOOTH) || (i == IDX_TORQUE_SCALE) ||
             (i == IDX_MAX_SPEED) || (i == IDX_STATUS) ||
             in_range(i, IDX_TQ_PRESET, N_TQ_PRESET) ||
             in_range(i, IDX_SP_PRESET, N_SP_PRESET) ||
             in_range(i, IDX_POS_PRESET, N_POS_PRESET);
   endfunction : reg_hit

   // Scale never exceeds 1000, so 10 V full scale fits in 16 bits
   function automatic logic signed [15:0] scale_torque(
      input logic signed [15:0] mv,
      input logic        [15:0] k);
      logic signed [33:0] p;
      p = mv * $signed({1'b0, k});
      p = p / TORQUE_DIV;
      return p[15:0];
   endfunction : scale_torque

   function automatic logic signed [15:0] clamp_speed(
      input logic signed [15:0] v,
      input logic        [15:0] m);
      logic signed [16:0] lim;
      logic signed [16:0] vv;
      lim = $signed({1'b0, m});
      vv  = {v[15], v};
      if (vv > lim)
         return lim[15:0];
      else if (vv < -lim)
         return 16'(-lim);
      else
         return v;
   endfunction : clamp_speed

   function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
      return v[15] ? 16'(-v) : v;
   endfunction : abs16

   assign idx     = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign cur     = s_q.stable;
   // Trigger edge only from debounced level, so bounce cannot latch twice
   assign trig_rise  = cur.position_trigger & ~s_q.trig_prev;
   assign pulse_rise = s_q.sync2.cmd_pulse & ~s_q.pulse_prev;
   // Analog samples come from a converter on pclk, so no synchroniser
   assign scaled        = scale_torque(analog_torque_mv, s_q.scale);
   assign pos_sel_value = s_q.pos_pre[cur.position_cmd_select];

   always_comb
   begin
      logic signed [16:0] diff;
      logic signed [16:0] step;
      logic               sw;
      diff = 17'sd0;
      step = 17'sd0;
      sw   = 1'b0;
      s_d  = s_q;
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;

      // Two-flop synchroniser and whole-vector debounce
      s_d.sync1 = di_pins;
      s_d.sync2 = s_q.sync1;
      if (s_q.sync2 != s_q.deb_last)
      begin
         s_d.deb_last = s_q.sync2;
         s_d.deb_cnt  = '0;
      end
      else if (s_q.deb_cnt == DEB_CNT_MAX)
         s_d.stable = s_q.sync2;
      else
         s_d.deb_cnt = s_q.deb_cnt + 1'b1;
      s_d.trig_prev  = cur.position_trigger;
      s_d.pulse_prev = s_q.sync2.cmd_pulse;

      // APB: setup cycle prepares the answer, access cycle completes
      if (psel && !penable)
      begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !aligned || !reg_hit(idx);
         s_d.prdata  = '0;
         if (in_range(idx, IDX_TQ_PRESET, N_TQ_PRESET))
            s_d.prdata = {16'h0000, s_q.tq_pre[idx - IDX_TQ_PRESET]};
         else if (in_range(idx, IDX_SP_PRESET, N_SP_PRESET))
            s_d.prdata = {16'h0000, s_q.sp_pre[idx - IDX_SP_PRESET]};
         else if (in_range(idx, IDX_POS_PRESET, N_POS_PRESET))
            s_d.prdata = s_q.pos_pre[idx - IDX_POS_PRESET];
         else
         begin
            case (idx)
               IDX_CTRL_MODE:     s_d.prdata = {24'h000000, s_q.mode};
               IDX_LIMIT_EN:      s_d.prdata = {24'h000000, s_q.limit_en};
               IDX_TORQUE_SMOOTH: s_d.prdata = {16'h0000, s_q.tau};
               IDX_TORQUE_SCALE:  s_d.prdata = {16'h0000, s_q.scale};
               IDX_MAX_SPEED:     s_d.prdata = {16'h0000, s_q.max_speed};
               IDX_STATUS:
               begin
                  s_d.prdata[ST_OP_LSB +: 3]     = s_q.op;
                  s_d.prdata[ST_SERVO_ON]        = cur.servo_on;
                  s_d.prdata[ST_HOLD]            = s_q.out.position_hold;
                  s_d.prdata[ST_SPD_LIMIT]       = s_q.out.speed_limit_on;
                  s_d.prdata[ST_DI_LSB +: IN_W]  = cur;
               end
               default:           s_d.prdata = '0;
            endcase
         end
      end
      if (psel && penable && s_q.pready && pwrite && aligned)
      begin
         if (in_range(idx, IDX_TQ_PRESET, N_TQ_PRESET))
            s_d.tq_pre[idx - IDX_TQ_PRESET] = pwdata[15:0];
         else if (in_range(idx, IDX_SP_PRESET, N_SP_PRESET))
            s_d.sp_pre[idx - IDX_SP_PRESET] = pwdata[15:0];
         else if (in_range(idx, IDX_POS_PRESET, N_POS_PRESET))
            s_d.pos_pre[idx - IDX_POS_PRESET] = pwdata;
         else
         begin
            case (idx)
               IDX_CTRL_MODE:
                  if (mode_ok(pwdata[7:0]))
                     s_d.mode = pwdata[7:0];
               IDX_LIMIT_EN:      s_d.limit_en = pwdata[7:0];
               IDX_TORQUE_SMOOTH:
                  s_d.tau = (pwdata[15:0] > TAU_MAX_MS) ? TAU_MAX_MS
                                                        : pwdata[15:0];
               IDX_TORQUE_SCALE:
                  s_d.scale = (pwdata[15:0] > SCALE_MAX) ? SCALE_MAX
                                                         : pwdata[15:0];
               IDX_MAX_SPEED:     s_d.max_speed = pwdata[15:0] & MAXSPD_MASK;
               default:           s_d.mode = s_q.mode;
            endcase
         end
      end

      // Dual mode selection
      case (s_q.mode)
         MODE_PULSE_SPEED:
            s_d.op = cur.speed_pos_sw ? OP_SPEED : OP_PULSE_POS;
         MODE_PULSE_TORQUE:
            s_d.op = cur.torque_pos_sw ? OP_PULSE_POS : OP_TORQUE;
         MODE_PRESET_SPEED, MODE_PRESET_TORQUE:
         begin
            sw = (s_q.mode == MODE_PRESET_SPEED) ? cur.speed_pos_sw
                                                 : cur.torque_pos_sw;
            if (sw)
               s_d.op = (s_q.mode == MODE_PRESET_SPEED) ? OP_SPEED
                                                        : OP_PRESET_POS;
            else if (s_q.mode == MODE_PRESET_TORQUE)
               s_d.op = OP_TORQUE;
            else
            begin
               case (s_q.op)
                  OP_PRESET_POS: s_d.op = OP_PRESET_POS;
                  OP_POS_WAIT:   s_d.op = trig_rise ? OP_PRESET_POS
                                                    : OP_POS_WAIT;
                  default:       s_d.op = trig_rise ? OP_PRESET_POS
                                                    : OP_POS_WAIT;
               endcase
               if (trig_rise)
                  s_d.pos = pos_sel_value;
            end
            // Preset/torque mode: entering position latches the selection
            if (sw && s_q.mode == MODE_PRESET_TORQUE && s_q.op != OP_PRESET_POS)
               s_d.pos = pos_sel_value;
         end
         default:
            s_d.op = cur.speed_torque_sw ? OP_TORQUE : OP_SPEED;
      endcase

      // Pulses counted only while in pulse position mode
      if (s_q.op == OP_PULSE_POS && pulse_rise)
         s_d.pcount = s_q.sync2.cmd_dir ? s_q.pcount - 1 : s_q.pcount + 1;

      // Torque smoothing; truncated steps may leave a small residual
      s_d.tick = (s_q.tick == TICK_LAST) ? '0 : s_q.tick + 1'b1;
      if (s_q.tau == 16'h0000)
         s_d.filt = scaled;
      else if (s_q.tick == TICK_LAST)
      begin
         diff     = {scaled[15], scaled} - {s_q.filt[15], s_q.filt};
         step     = diff / $signed({1'b0, s_q.tau});
         s_d.filt = 16'({s_q.filt[15], s_q.filt} + step);
      end

      // Command outputs
      s_d.out.op_mode = s_q.op;
      if (!cur.servo_on)
         s_d.out.torque = 16'sh0000;
      else
         s_d.out.torque = torque_src;
      s_d.out.speed = clamp_speed(speed_src, s_q.max_speed);
      if (s_q.op == OP_TORQUE && s_q.limit_en[LIMIT_EN_SPEED_BIT])
      begin
         s_d.out.speed_limit    = clamp_speed(abs16(speed_src),
                                              s_q.max_speed);
         s_d.out.speed_limit_on = 1'b1;
      end
      else
      begin
         s_d.out.speed_limit    = s_q.max_speed;
         s_d.out.speed_limit_on = 1'b0;
      end
      s_d.out.position      = (s_q.op == OP_PULSE_POS) ? s_q.pcount : s_q.pos;
      s_d.out.position_hold = (s_q.op == OP_POS_WAIT);
      s_d.out.pulse_count   = s_q.pcount;
   end

   // Selector zero takes the analog source (filtered for torque, unfiltered for speed), else a preset
   always_comb
   begin
      if (cur.torque_cmd_select == 2'b00)
         torque_src = s_q.filt;
      else
         torque_src = s_q.tq_pre[cur.torque_cmd_select - 2'b01];
      if (cur.speed_cmd_select == 2'b00)
         speed_src = analog_speed;
      else
         speed_src = s_q.sp_pre[cur.speed_cmd_select - 2'b01];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q           <= '0;
         s_q.mode      <= MODE_RST;
         s_q.limit_en  <= LIMIT_EN_RST;
         s_q.tau       <= TAU_RST;
         s_q.scale     <= SCALE_RST;
         s_q.max_speed <= MAXSPD_RST;
         s_q.op        <= OP_SPEED;
      end
      else
         s_q <= s_d;
   end

   assign prdata    = s_q.prdata;
   assign pready    = s_q.pready;
   assign pslverr   = s_q.pslverr;
   assign drive_cmd = s_q.out;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence steady_analog_s;
      (s_q.tau == 16'h0000 && cur.servo_on &&
       cur.torque_cmd_select == 2'b00)[*3];
   endsequence
   sequence trig_latch_s;
      trig_rise && s_q.mode == MODE_PRESET_SPEED && !cur.speed_pos_sw;
   endsequence

   smooth_bypass_a:
      assert property ((s_q.tau == 16'h0000) |=> (s_q.filt == $past(scaled)))
      else $error("torque filter not bypassed");
   analog_torque_a:
      assert property (steady_analog_s |-> s_q.out.torque == $past(scaled, 2))
      else $error("analog torque command wrong");
   servo_off_a:
      assert property (!cur.servo_on |=> s_q.out.torque == 16'sh0000)
      else $error("torque not zero with servo off");
   mode_code_a:
      assert property (mode_ok(s_q.mode))
      else $error("control mode code out of dual range");
   speed_trig_a:
      assert property ((s_q.mode == MODE_PRESET_SPEED && cur.speed_pos_sw)
                       |=> s_q.op == OP_SPEED && $stable(s_q.pos))
      else $error("speed mode not held or trigger acted");
   hold_wait_a:
      assert property (s_q.op == OP_POS_WAIT |=> s_q.out.position_hold)
      else $error("motor not held while position undetermined");
   trig_latch_a:
      assert property (trig_latch_s |=> s_q.op == OP_PRESET_POS &&
                       s_q.pos == $past(pos_sel_value))
      else $error("trigger edge did not latch position");
   st_switch_a:
      assert property (s_q.mode == MODE_SPEED_TORQUE |=> s_q.op ==
                       ($past(cur.speed_torque_sw) ? OP_TORQUE : OP_SPEED))
      else $error("speed torque switch not followed");
   pulse_count_a:
      assert property ((s_q.op == OP_PULSE_POS && pulse_rise &&
                        !s_q.sync2.cmd_dir) |=> s_q.pcount == $past(s_q.pcount) + 1)
      else $error("command pulse not counted");
   pulse_stop_a:
      assert property (s_q.op != OP_PULSE_POS |=> $stable(s_q.pcount))
      else $error("pulses counted outside position mode");
   tp_resume_a:
      assert property ((s_q.mode == MODE_PULSE_TORQUE && cur.torque_pos_sw)
                       |=> s_q.op == OP_PULSE_POS)
      else $error("position mode not resumed");
   speed_clamp_a:
      assert property ({s_q.out.speed[15], s_q.out.speed} <=
                       $signed({1'b0, $past(s_q.max_speed)}))
      else $error("speed exceeds maximum");
   limit_gate_a:
      assert property (!(s_q.op == OP_TORQUE &&
                         s_q.limit_en[LIMIT_EN_SPEED_BIT])
                       |=> !s_q.out.speed_limit_on)
      else $error("speed limit active without enable");
   debounce_a:
      assert property ($changed(s_q.stable) |->
                       s_q.stable == $past(s_q.sync2) &&
                       $past(s_q.deb_cnt) == DEB_CNT_MAX)
      else $error("input changed before debounce time");
endmodule : servo_control_mode_selector

`default_nettype wire

/* inc/servo_mode_pkg.sv */
// Constants, register map and carrier types of the servo mode selector
package servo_mode_pkg;
   // Timing
   localparam int CLK_MHZ            = 25;
   localparam int DEBOUNCE_NS        = 400;
   localparam int DEBOUNCE_CYCLES    = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam int FILTER_STEP_US     = 1000;
   localparam int FILTER_STEP_CYCLES = FILTER_STEP_US * CLK_MHZ;
   localparam int DEB_W              = 8;
   localparam int TICK_W             = 24;

   // Torque scaling: 0.1 % units = mV * scale / (1000 mV/V * 10) * 10
   localparam int MV_PER_V       = 1000;
   localparam int SCALE_DIV      = 10;
   localparam int TENTHS_PER_PCT = 10;
   localparam int TORQUE_DIV     = MV_PER_V * SCALE_DIV / TENTHS_PER_PCT;

   // APB map: register index, byte address is four times the index
   localparam int ADDR_W = 14;
   localparam int IDX_W  = 12;
   localparam logic [IDX_W-1:0] IDX_CTRL_MODE     = 12'h100;
   localparam logic [IDX_W-1:0] IDX_LIMIT_EN      = 12'h102;
   localparam logic [IDX_W-1:0] IDX_TORQUE_SMOOTH = 12'h107;
   localparam logic [IDX_W-1:0] IDX_TORQUE_SCALE  = 12'h110;
   localparam logic [IDX_W-1:0] IDX_MAX_SPEED     = 12'h111;
   localparam logic [IDX_W-1:0] IDX_STATUS        = 12'h112;
   localparam logic [IDX_W-1:0] IDX_TQ_PRESET     = 12'h120;
   localparam logic [IDX_W-1:0] IDX_SP_PRESET     = 12'h124;
   localparam logic [IDX_W-1:0] IDX_POS_PRESET    = 12'h130;
   localparam int N_TQ_PRESET  = 3;
   localparam int N_SP_PRESET  = 3;
   localparam int N_POS_PRESET = 8;

   // Reset values and limits
   localparam logic [7:0]  MODE_RST     = 8'h06;
   localparam logic [7:0]  LIMIT_EN_RST = 8'h00;
   localparam logic [15:0] TAU_RST      = 16'h0000;
   localparam logic [15:0] TAU_MAX_MS   = 16'h03E8;
   localparam logic [15:0] SCALE_RST    = 16'h0064;
   localparam logic [15:0] SCALE_MAX    = 16'h03E8;
   localparam logic [15:0] MAXSPD_RST   = 16'h0BB8;
   localparam logic [15:0] MAXSPD_MASK  = 16'h7FFF;
   localparam int LIMIT_EN_SPEED_BIT = 0;

   // Dual control mode codes
   localparam logic [7:0] MODE_PULSE_SPEED   = 8'h06;
   localparam logic [7:0] MODE_PULSE_TORQUE  = 8'h07;
   localparam logic [7:0] MODE_PRESET_SPEED  = 8'h08;
   localparam logic [7:0] MODE_PRESET_TORQUE = 8'h09;
   localparam logic [7:0] MODE_SPEED_TORQUE  = 8'h0A;

   // Status register fields
   localparam int ST_OP_LSB    = 0;
   localparam int ST_SERVO_ON  = 3;
   localparam int ST_HOLD      = 4;
   localparam int ST_SPD_LIMIT = 5;
   localparam int ST_DI_LSB    = 8;

   typedef enum logic [2:0] {
      OP_SPEED      = 3'b000,
      OP_TORQUE     = 3'b001,
      OP_PULSE_POS  = 3'b010,
      OP_PRESET_POS = 3'b011,
      OP_POS_WAIT   = 3'b100
   } op_mode_t;

   typedef struct packed {
      logic       servo_on;
      logic       speed_pos_sw;
      logic       speed_torque_sw;
      logic       torque_pos_sw;
      logic       position_trigger;
      logic [1:0] torque_cmd_select;
      logic [1:0] speed_cmd_select;
      logic [2:0] position_cmd_select;
      logic       cmd_pulse;
      logic       cmd_dir;
   } di_pins_t;

   localparam int IN_W = $bits(di_pins_t);

   typedef struct packed {
      op_mode_t           op_mode;
      logic signed [15:0] torque;
      logic signed [15:0] speed;
      logic        [15:0] speed_limit;
      logic               speed_limit_on;
      logic signed [31:0] position;
      logic               position_hold;
      logic signed [31:0] pulse_count;
   } drive_cmd_t;
endpackage : servo_mode_pkg

/* sim/motion_ctrl_model.sv */
// Motion controller model driving the switch pins and the pulse train
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model
(
   input  wire logic                 pclk,
   input  wire servo_mode_pkg::di_pins_t levels,
   output servo_mode_pkg::di_pins_t  di_pins
);
   import servo_mode_pkg::*;
   logic pulse_q = 1'b0;
   always_comb
   begin
      di_pins = levels;
      di_pins.cmd_pulse = pulse_q;
   end
   // Rising edge every 4 cycles, within the one per 2 pclk spacing
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge pclk) pulse_q <= 1'b1;
         repeat (2) @(posedge pclk);
         pulse_q <= 1'b0;
         @(posedge pclk);
      end
   endtask : pulses
endmodule : motion_ctrl_model
`default_nettype wire

/* sim/tb_top.sv */
// Register and mode switching testbench of the servo mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import servo_mode_pkg::*;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [ADDR_W-1:0]  paddr = '0;
   logic [31:0]        pwdata = '0;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   di_pins_t           lv = '0;
   di_pins_t           di;
   logic signed [15:0] atq = '0;
   logic signed [15:0] asp = '0;
   drive_cmd_t         dc;
   logic [31:0]        rd;
   logic               er;
   int                 error_cnt = 0;
   int                 total_checks = 0;
   always #20 pclk = ~pclk;
   servo_control_mode_selector #(.TICK_CYCLES(4)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .di_pins(di), .analog_torque_mv(atq),
      .analog_speed(asp), .drive_cmd(dc));
   motion_ctrl_model ctl (.pclk(pclk), .levels(lv), .di_pins(di));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      // A slave that never answers counts against the run
      if (n >= 50)
         error_cnt++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle();
      repeat (20) @(posedge pclk);
   endtask : settle
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      test_done();
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, IDX_CTRL_MODE, 0);
      chk(rd, 32'h6);
      apb(0, IDX_TORQUE_SMOOTH, 0);
      chk(rd, 32'h0);
      apb(0, 12'h000, 0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      apb(1, IDX_CTRL_MODE, 32'h0B);
      apb(0, IDX_CTRL_MODE, 0);
      chk(rd, 32'h6);
      apb(1, IDX_CTRL_MODE, 32'h0A);
      apb(0, IDX_CTRL_MODE, 0);
      chk(rd, 32'hA);
      $display("registers done");
      apb(1, IDX_TORQUE_SCALE, 32'hC8);
      apb(1, IDX_LIMIT_EN, 32'h1);
      apb(1, IDX_MAX_SPEED, 32'h64);
      atq <= 16'sd5000;
      asp <= 16'sd500;
      lv.servo_on <= 1'b1;
      lv.speed_torque_sw <= 1'b1;
      settle();
      chk(dc.op_mode, OP_TORQUE);
      chk(dc.torque, 32'h3E8);
      chk(dc.speed_limit_on, 1'b1);
      chk(dc.speed_limit, 32'h64);
      lv.servo_on <= 1'b0;
      settle();
      chk(dc.torque, 32'h0);
      lv.speed_torque_sw <= 1'b0;
      settle();
      chk(dc.op_mode, OP_SPEED);
      chk(dc.speed, 32'h64);
      chk(dc.speed_limit_on, 1'b0);
      $display("speed torque done");
      apb(1, IDX_POS_PRESET + 12'h5, 32'h1234);
      lv.speed_pos_sw <= 1'b1;
      lv.position_cmd_select <= 3'h5;
      apb(1, IDX_CTRL_MODE, 32'h08);
      settle();
      lv.position_trigger <= 1'b1;
      settle();
      chk(dc.op_mode, OP_SPEED);
      lv.position_trigger <= 1'b0;
      lv.speed_pos_sw <= 1'b0;
      settle();
      chk({dc.op_mode, dc.position_hold}, {OP_POS_WAIT, 1'b1});
      lv.position_trigger <= 1'b1;
      settle();
      chk(dc.op_mode, OP_PRESET_POS);
      chk(dc.position, 32'h1234);
      lv.speed_pos_sw <= 1'b1;
      settle();
      chk(dc.op_mode, OP_SPEED);
      $display("speed position done");
      apb(1, IDX_CTRL_MODE, 32'h07);
      lv.torque_pos_sw <= 1'b1;
      settle();
      ctl.pulses(10);
      settle();
      chk(dc.pulse_count, 32'hA);
      lv.torque_pos_sw <= 1'b0;
      settle();
      chk(dc.op_mode, OP_TORQUE);
      ctl.pulses(10);
      settle();
      chk(dc.pulse_count, 32'hA);
      lv.torque_pos_sw <= 1'b1;
      settle();
      chk(dc.op_mode, OP_PULSE_POS);
      $display("torque position done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
